//--- rtl/rtcpt_pkg.sv
// shared constants for the rtc output pin and trim blocks
package rtcpt_pkg;
  // device register addresses on the link
  localparam logic [4:0] ADDR_CONTROL = 5'h07;
  localparam logic [4:0] ADDR_TRIM = 5'h08;
  localparam logic [4:0] ADDR_WKDAY0 = 5'h0D;
  localparam logic [4:0] ADDR_WKDAY1 = 5'h14;
  // clock_control fields
  localparam int CTL_OUT = 7;
  localparam int CTL_SQW = 6;
  localparam int CTL_AL1 = 5;
  localparam int CTL_AL0 = 4;
  localparam int CTL_EXT = 3;
  localparam int CTL_CRS = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h80;
  // oscillator_trim and weekday fields
  localparam int TRIM_SIGN = 7;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam int WK_POL = 7;
  localparam int WK_FLAG = 3;
  localparam logic [5:0] WKDAY_RESET = 6'h00;
  // square wave selects and divider taps
  localparam logic [1:0] FS_1HZ = 2'h0;
  localparam logic [1:0] FS_4K = 2'h1;
  localparam logic [1:0] FS_8K = 2'h2;
  localparam int TAP_1HZ = 14;
  localparam int TAP_4K = 2;
  localparam int TAP_8K = 1;
  localparam int TAP_64HZ = 8;
  // timekeeping and trim figures
  localparam logic [5:0] LAST_SEC = 6'h3B;
  localparam int OSC_HZ = 32768;
  localparam int SEC_PER_MIN = 60;
  localparam int PULSES_PER_STEP = 2;
  localparam int CAL_SCALE = OSC_HZ * SEC_PER_MIN / PULSES_PER_STEP;
  // host timing
  localparam int CLK_HZ = 100_000_000;
  localparam int GATE_MS = 1000;
  localparam int GATE_CYCLES = GATE_MS * (CLK_HZ / 1000);
  // host wishbone offsets and fields
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_CAL = 8'h08;
  localparam logic [7:0] HOST_IDEAL = 8'h0C;
  localparam logic [7:0] HOST_RESULT = 8'h10;
  localparam logic [7:0] HOST_IRQ_STAT = 8'h14;
  localparam logic [7:0] HOST_IRQ_MASK = 8'h18;
  localparam int CMD_WRITE = 16;
  localparam int CMD_READ = 17;
  localparam int CAL_EXT = 2;
  localparam int CAL_GO = 3;
  localparam int IRQ_ACC = 0;
  localparam int IRQ_CAL = 1;
  localparam int IRQ_PIN = 2;
endpackage

//--- rtl/rtcpt_link_if.sv
// link between host and device: register port and open-drain pin
`timescale 1ns/1ps
interface rtcpt_link_if;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic mfpOut;
  logic mfpOe;
  logic mfpLevel;
  // pull-up: released pin reads high
  assign mfpLevel = mfpOe ? 1'b1 : mfpOut;
  modport dev (input addr, input wdata, input wr, input rd, output rdata,
    output mfpOut, output mfpOe);
  modport host (output addr, output wdata, output wr, output rd, input rdata,
    input mfpLevel);
endinterface

//--- rtl/rtcpt_divider.sv
// sequential restoring divider used by the host calibration
`timescale 1ns/1ps
module rtcpt_divider
#(
  parameter int W = 44
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic done,
  output logic [W-1:0] quo
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0] rem;
  logic [W-1:0] denReg;
  logic [CW-1:0] cnt;
  wire [W:0] trial = {rem, quo[W-1]} - {1'b0, denReg};
  wire fits = ~trial[W];
  wire busy = cnt != '0;
  // refuse widths the shift logic cannot serve
  if (W < 2)
  begin
    $error("divider width too small");
  end
  // one quotient bit per cycle, msb first
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rem <= '0;
      quo <= '0;
      denReg <= '0;
      cnt <= '0;
      done <= 1'b0;
    end
    else if (start)
    begin
      rem <= '0;
      quo <= num;
      denReg <= den;
      cnt <= CW'(W);
      done <= 1'b0;
    end
    else
    begin
      done <= busy && cnt == CW'(1);
      if (busy)
      begin
        rem <= fits ? trial[W-1:0] : {rem[W-2:0], quo[W-1]};
        quo <= {quo[W-2:0], fits};
        cnt <= cnt - CW'(1);
      end
    end
  end
endmodule

//--- rtl/rtcpt_device.sv
// device end: multi-function pin mux, alarm flags and oscillator trim
`timescale 1ns/1ps
// What this block does
// - enabled alarms without square wave drive pin
// - single alarm: pin follows flag per polarity
// - both alarms, polarity one: OR of flags
// - both alarms, polarity zero: inverted AND
// - nothing enabled: pin follows general purpose level
// - fine trim applied once per minute automatically
// - sign set adds cycles, clear subtracts
// - each trim step is two oscillator pulses
// - zero trim amount disables trimming entirely
// - coarse trim applies 128 times per second
// - full trim amount moves 254 cycles
// - host calibrates via zero trim, square wave
// - fast oscillator: host clears sign bit
// - slow oscillator: host sets sign bit
// - host trim from scaled frequency error
// - square wave enable overrides other pin modes
// - flags set by match, cleared by write
// - coarse trim square wave gives 64 Hz
module rtcpt_device
  import rtcpt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  rtcpt_link_if.dev lnk,
  input wire logic oscIn,
  input wire logic alarm0Match,
  input wire logic alarm1Match,
  output logic secondTick,
  output logic trimEvent
);
  logic oscMeta;
  logic oscSync;
  logic oscPrev;
  logic [7:0] control;
  logic [7:0] trim;
  logic [5:0] wk0;
  logic [5:0] wk1;
  logic polarity;
  logic flag0;
  logic flag1;
  logic [14:0] cyc;
  logic [5:0] secCnt;
  logic [7:0] owed;
  logic [7:0] rdata;
  logic mfpOut;
  logic mfpOe;

  // oscillator edge from the synchronised pin
  wire oscRise = oscSync & ~oscPrev;

  // register write decode
  wire wrCtl = lnk.wr && lnk.addr == ADDR_CONTROL;
  wire wrTrim = lnk.wr && lnk.addr == ADDR_TRIM;
  wire wrWk0 = lnk.wr && lnk.addr == ADDR_WKDAY0;
  wire wrWk1 = lnk.wr && lnk.addr == ADDR_WKDAY1;

  // control fields
  wire square_wave_enable = control[CTL_SQW];
  wire al0En = control[CTL_AL0];
  wire al1En = control[CTL_AL1];
  wire coarse = control[CTL_CRS];
  wire [1:0] freqSel = control[1:0];
  wire trimSign = trim[TRIM_SIGN];
  wire [6:0] trimAmt = trim[6:0];

  // flags: a match in the clearing cycle still sets
  wire next_flag0 = alarm0Match | (flag0 & ~wrWk0);
  wire next_flag1 = alarm1Match | (flag1 & ~wrWk1);

  // polarity shared by both weekday registers
  wire next_polarity = (wrWk0 | wrWk1) ? lnk.wdata[WK_POL] : polarity;

  // counted increment: stall to subtract, double step to add
  wire owing = owed != 8'h00;
  wire [1:0] incSub = trimSign ? 2'h2 : 2'h0;
  wire [1:0] inc = !oscRise ? 2'h0 : owing ? incSub : 2'h1;
  wire [15:0] cycSum = {1'b0, cyc} + {14'h0, inc};
  wire [8:0] lowSum = {1'b0, cyc[7:0]} + {7'h0, inc};
  wire secWrap = cycSum[15];
  wire minuteEnd = secWrap && secCnt == LAST_SEC;

  // trim event: per minute, or every 256 cycles in coarse mode
  wire trimOn = trimAmt != 7'h00;
  wire trimSlot = coarse ? lowSum[8] : minuteEnd;
  wire trimDue = trimOn && trimSlot;

  // pulses owed: two per unit, 254 at full scale
  // a slot that comes while pulses are still owed adds to them, so the
  // coarse rate holds; beyond one extra pulse per edge the debt saturates
  wire [7:0] owedLoad = {trimAmt, 1'b0};
  wire [7:0] owedDec = (oscRise && owing) ? owed - 8'h01 : owed;
  wire [8:0] owedAdd = {1'b0, owedDec} + {1'b0, owedLoad};
  wire [7:0] owedSum = owedAdd[8] ? 8'hFF : owedAdd[7:0];
  wire [7:0] next_owed = !trimOn ? 8'h00 : trimDue ? owedSum : owedDec;

  // seconds within the minute
  wire [5:0] secInc = (secCnt == LAST_SEC) ? 6'h00 : secCnt + 6'h01;
  wire [5:0] next_secCnt = secWrap ? secInc : secCnt;

  // square wave tap from the trimmed counter, or the synchronised oscillator for the fourth select
  wire fsTap = (freqSel == FS_1HZ) ? cyc[TAP_1HZ] :
    (freqSel == FS_4K) ? cyc[TAP_4K] :
    (freqSel == FS_8K) ? cyc[TAP_8K] : oscSync;
  wire sqBit = coarse ? cyc[TAP_64HZ] : fsTap;

  // alarm interrupt level
  wire alarmAny = al0En | al1En;
  wire alarmBoth = al0En & al1En;
  wire singleFlag = al0En ? flag0 : flag1;
  wire singleLevel = polarity ? singleFlag : ~singleFlag;
  wire bothOr = flag0 | flag1;
  wire bothNand = ~(flag0 & flag1);
  wire bothLevel = polarity ? bothOr : bothNand;
  wire alarmLevel = alarmBoth ? bothLevel : singleLevel;

  // pin mode priority: square wave, alarm, general purpose
  wire gpLevel = control[CTL_OUT];
  wire modeLevel = alarmAny ? alarmLevel : gpLevel;
  wire pinLevel = square_wave_enable ? sqBit : modeLevel;

  // readback mux, unmapped addresses read zero
  wire [7:0] wkRead0 = {polarity, wk0[5:3], flag0, wk0[2:0]};
  wire [7:0] wkRead1 = {polarity, wk1[5:3], flag1, wk1[2:0]};
  wire [7:0] rdMux = (lnk.addr == ADDR_CONTROL) ? control :
    (lnk.addr == ADDR_TRIM) ? trim :
    (lnk.addr == ADDR_WKDAY0) ? wkRead0 :
    (lnk.addr == ADDR_WKDAY1) ? wkRead1 : 8'h00;

  // two-flop synchroniser and edge history
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
      oscPrev <= 1'b0;
    end
    else
    begin
      oscMeta <= oscIn;
      oscSync <= oscMeta;
      oscPrev <= oscSync;
    end
  end

  // control and trim registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      control <= CONTROL_RESET;
      trim <= TRIM_RESET;
    end
    else
    begin
      if (wrCtl)
        control <= lnk.wdata;
      if (wrTrim)
        trim <= lnk.wdata;
    end
  end

  // weekday configuration, flags and polarity
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wk0 <= WKDAY_RESET;
      wk1 <= WKDAY_RESET;
      polarity <= 1'b0;
      flag0 <= 1'b0;
      flag1 <= 1'b0;
    end
    else
    begin
      if (wrWk0)
        wk0 <= {lnk.wdata[6:4], lnk.wdata[2:0]};
      if (wrWk1)
        wk1 <= {lnk.wdata[6:4], lnk.wdata[2:0]};
      polarity <= next_polarity;
      flag0 <= next_flag0;
      flag1 <= next_flag1;
    end
  end

  // trimmed cycle counter and seconds
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cyc <= 15'h0000;
      secCnt <= 6'h00;
      owed <= 8'h00;
      secondTick <= 1'b0;
      trimEvent <= 1'b0;
    end
    else
    begin
      cyc <= cycSum[14:0];
      secCnt <= next_secCnt;
      owed <= next_owed;
      secondTick <= secWrap;
      trimEvent <= trimDue;
    end
  end

  // registered read data and open-drain pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= 8'h00;
      mfpOut <= 1'b1;
      mfpOe <= 1'b1;
    end
    else
    begin
      if (lnk.rd)
        rdata <= rdMux;
      mfpOut <= pinLevel;
      mfpOe <= pinLevel;
    end
  end

  // drive the link
  assign lnk.rdata = rdata;
  assign lnk.mfpOut = mfpOut;
  assign lnk.mfpOe = mfpOe;
endmodule

//--- rtl/rtcpt_host.sv
// host end: wishbone command port, link access and calibration sequence
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module rtcpt_host
  import rtcpt_pkg::*;
#(
  parameter int GATE = GATE_CYCLES
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq,
  rtcpt_link_if.host lnk
);
  typedef enum {H_IDLE, H_RD_WAIT, H_RD_TAKE, H_CAL_TRIM0, H_CAL_SQW,
    H_CAL_GATE, H_CAL_DIV, H_CAL_LOAD} rtcpt_hstate_t;
  rtcpt_hstate_t state;
  logic [7:0] rdData;
  logic [1:0] calFs;
  logic calExt;
  logic [23:0] ideal;
  logic [23:0] meas;
  logic [7:0] trimResult;
  logic [2:0] irqStat;
  logic [2:0] irqMask;
  logic [31:0] gateCnt;
  logic slow;
  logic pinMeta;
  logic pinSync;
  logic pinPrev;
  logic divDone;
  logic [43:0] divQuo;
  // refuse a gate too short to count anything
  if (GATE < 2)
  begin
    $error("gate window too short");
  end

  // wishbone decode, one access per ack
  wire wbReq = cyc_i & stb_i & ~ack_o;
  wire wbWr = wbReq & we_i;
  wire idle = state == H_IDLE;
  wire cmdGo = wbWr && adr_i == HOST_CMD && sel_i[2:0] == 3'h7 && idle;
  wire calGo = wbWr && adr_i == HOST_CAL && sel_i[0] && dat_i[CAL_GO] && idle;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] idealMix = ({8'h00, ideal} & ~wmask) | (dat_i & wmask);
  wire [2:0] irqClr = (wbWr && adr_i == HOST_IRQ_STAT && sel_i[0]) ? dat_i[2:0] : 3'h0;
  wire [31:0] rdMux = (adr_i == HOST_STATUS) ? {23'h0, ~idle, rdData} :
    (adr_i == HOST_CAL) ? {29'h0, calExt, calFs} :
    (adr_i == HOST_IDEAL) ? {8'h00, ideal} :
    (adr_i == HOST_RESULT) ? {meas, trimResult} :
    (adr_i == HOST_IRQ_STAT) ? {29'h0, irqStat} :
    (adr_i == HOST_IRQ_MASK) ? {29'h0, irqMask} : 32'h0;

  // error counts: positive means slow oscillator
  wire [24:0] errDiff = {1'b0, ideal} - {1'b0, meas};
  wire [24:0] errNeg = 25'h0 - errDiff;
  wire [23:0] absErr = errDiff[24] ? errNeg[23:0] : errDiff[23:0];
  wire errSlow = ~errDiff[24] & (errDiff != 25'h0);
  wire [43:0] divNum = 44'(absErr) * 44'(CAL_SCALE);
  wire gateEnd = gateCnt == 32'(GATE - 1);
  wire divStart = state == H_CAL_GATE && gateEnd;
  wire [6:0] trimSat = (|divQuo[43:7]) ? 7'h7F : divQuo[6:0];

  // events, set wins over clear
  wire pinRise = pinSync & ~pinPrev;
  wire pinFall = pinPrev & ~pinSync;
  wire evAcc = (cmdGo && dat_i[CMD_WRITE]) || state == H_RD_TAKE;
  wire evCal = state == H_CAL_LOAD;
  wire [2:0] events = {pinFall, evCal, evAcc};
  wire [2:0] next_irqStat = (irqStat & ~irqClr) | events;

  rtcpt_divider #(.W(44)) u_div (
    .clk(clk),
    .arst_n(arst_n),
    .start(divStart),
    .num(divNum),
    .den(44'(ideal)),
    .done(divDone),
    .quo(divQuo)
  );

  // wishbone slave registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
      calFs <= 2'h0;
      calExt <= 1'b0;
      ideal <= 24'h0;
      irqMask <= 3'h0;
      irqStat <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      ack_o <= wbReq;
      dat_o <= wbReq ? rdMux : 32'h0;
      if (calGo)
        {calExt, calFs} <= dat_i[2:0];
      if (wbWr && adr_i == HOST_IDEAL && idle)
        ideal <= idealMix[23:0];
      if (wbWr && adr_i == HOST_IRQ_MASK && sel_i[0])
        irqMask <= dat_i[2:0];
      irqStat <= next_irqStat;
      irq <= |(next_irqStat & irqMask);
    end
  end

  // pin synchroniser
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
      pinPrev <= 1'b1;
    end
    else
    begin
      pinMeta <= lnk.mfpLevel;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // link access and calibration sequence
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= H_IDLE;
      lnk.addr <= 5'h00;
      lnk.wdata <= 8'h00;
      lnk.wr <= 1'b0;
      lnk.rd <= 1'b0;
      rdData <= 8'h00;
      meas <= 24'h0;
      gateCnt <= 32'h0;
      trimResult <= 8'h00;
      slow <= 1'b0;
    end
    else
    begin
      lnk.wr <= 1'b0;
      lnk.rd <= 1'b0;
      unique case (state)
        H_IDLE:
        begin
          if (cmdGo)
          begin
            lnk.addr <= dat_i[12:8];
            lnk.wdata <= dat_i[7:0];
            lnk.wr <= dat_i[CMD_WRITE];
            lnk.rd <= ~dat_i[CMD_WRITE] & dat_i[CMD_READ];
            if (~dat_i[CMD_WRITE] & dat_i[CMD_READ])
              state <= H_RD_WAIT;
          end
          else if (calGo)
            state <= H_CAL_TRIM0;
        end
        H_RD_WAIT:
          state <= H_RD_TAKE;
        H_RD_TAKE:
        begin
          rdData <= lnk.rdata;
          state <= H_IDLE;
        end
        H_CAL_TRIM0:
        begin
          lnk.addr <= ADDR_TRIM;
          lnk.wdata <= 8'h00;
          lnk.wr <= 1'b1;
          state <= H_CAL_SQW;
        end
        H_CAL_SQW:
        begin
          lnk.addr <= ADDR_CONTROL;
          lnk.wdata <= {1'b1, 1'b1, 2'b00, calExt, 1'b0, calFs};
          lnk.wr <= 1'b1;
          gateCnt <= 32'h0;
          meas <= 24'h0;
          state <= H_CAL_GATE;
        end
        H_CAL_GATE:
        begin
          gateCnt <= gateCnt + 32'h1;
          if (pinRise)
            meas <= meas + 24'h1;
          if (gateEnd)
          begin
            slow <= errSlow;
            state <= H_CAL_DIV;
          end
        end
        H_CAL_DIV:
          if (divDone)
          begin
            trimResult <= {slow, trimSat};
            state <= H_CAL_LOAD;
          end
        H_CAL_LOAD:
        begin
          lnk.addr <= ADDR_TRIM;
          lnk.wdata <= trimResult;
          lnk.wr <= 1'b1;
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule

//--- verification/rtcpt_monitor.sv
// concurrent checks on the host to device link and the pin
`timescale 1ns/1ps
module rtcpt_monitor
  import rtcpt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic mfpOut,
  input wire logic mfpOe,
  input wire logic mfpLevel
);
  logic [7:0] ctl;
  logic [7:0] trim;
  logic pol;
  // address decode and pin mode of the shadow control
  wire wkSel = (addr == ADDR_WKDAY0) || (addr == ADDR_WKDAY1);
  wire known = (addr == ADDR_CONTROL) || (addr == ADDR_TRIM) || wkSel;
  wire gpMode = (ctl[6:4] == 3'h0);

  // shadow copies of what was written over the link
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl <= CONTROL_RESET;
      trim <= TRIM_RESET;
      pol <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == ADDR_CONTROL)
        ctl <= wdata;
      if (addr == ADDR_TRIM)
        trim <= wdata;
      if (wkSel)
        pol <= wdata[WK_POL];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // control write that selects plain output mode
  sequence s_gpWrite;
    wr && addr == ADDR_CONTROL && wdata[6:4] == 3'h0;
  endsequence
  // plain output mode with control unchanged for two samples
  sequence s_gpSteady;
    (gpMode && $stable(ctl)) [*2];
  endsequence

  gp_write_a: assert property (s_gpWrite |-> ##2 mfpLevel == $past(wdata[CTL_OUT], 2))
    else $error("pin differs from written output level");
  gp_hold_a: assert property (s_gpSteady |-> mfpLevel == ctl[CTL_OUT])
    else $error("pin differs from held output level");
  drive_low_a: assert property (!mfpOe |-> !mfpOut)
    else $error("pin driven high while enabled");
  trim_read_a: assert property (rd && addr == ADDR_TRIM |=> rdata == trim)
    else $error("trim readback wrong");
  ctl_read_a: assert property (rd && addr == ADDR_CONTROL |=> rdata == ctl)
    else $error("control readback wrong");
  unmapped_read_a: assert property (rd && !known |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  shared_pol_a: assert property (rd && wkSel |=> rdata[WK_POL] == pol)
    else $error("polarity bit not shared");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
endmodule

//--- verification/rtc_output_pin_and_trim_tb_top.sv
// self-checking bench: host and device joined over the link
`timescale 1ns/1ps
module rtc_output_pin_and_trim_tb_top
  import rtcpt_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic oscIn = 1'b0;
  logic m0 = 1'b0;
  logic m1 = 1'b0;
  int pinCount = 0;
  int oscCount = 0;
  int evCount = 0;
  logic trimEv;
  int fail_count = 0;
  int n_checks = 0;

  rtcpt_link_if lnk ();
  rtcpt_device i_rtcpt_device (.clk(clk), .arst_n(arst_n), .lnk(lnk.dev), .oscIn(oscIn),
    .alarm0Match(m0), .alarm1Match(m1), .secondTick(), .trimEvent(trimEv));
  rtcpt_host #(.GATE(2000)) i_rtcpt_host (.clk(clk), .arst_n(arst_n), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(4'hF), .dat_o(rdat),
    .ack_o(ack), .irq(irq), .lnk(lnk.host));
  rtcpt_monitor i_rtcpt_monitor (.clk(clk), .arst_n(arst_n), .addr(lnk.addr),
    .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata), .mfpOut(lnk.mfpOut),
    .mfpOe(lnk.mfpOe), .mfpLevel(lnk.mfpLevel));

  // system clock and a slower oscillator stand-in
  always #5 clk = ~clk;
  always
  begin
    repeat (2) @(posedge clk);
    oscIn <= ~oscIn;
  end
  // edge counters for pin and oscillator
  always @(posedge lnk.mfpLevel)
    pinCount++;
  always @(posedge oscIn)
    oscCount++;
  // trim adjustment events seen from the device
  always @(posedge clk)
    if (trimEv)
      evCount <= evCount + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // one link access through the host command register
  task automatic lacc(input logic rw, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] r);
    logic [31:0] q;
    wb(1'b1, HOST_CMD, {14'h0, ~rw, rw, 3'h0, a, d}, q);
    do wb(1'b0, HOST_STATUS, 32'h0, q); while (q[8] !== 1'b0);
    r = q[7:0];
  endtask

  // expected pin level in plain and alarm modes
  function automatic logic pinExp(logic [7:0] c, logic p, logic f0, logic f1);
    if (c[6:4] == 3'h0)
      return c[7];
    if (p)
      return (c[4] & f0) | (c[5] & f1);
    return ~((f0 | ~c[4]) & (f1 | ~c[5]));
  endfunction

  // oscillator edges per 64 Hz pin period under coarse trim
  function automatic int trimPeriod(logic [7:0] t);
    return t[TRIM_SIGN] ? 512 - 4 * t[6:0] : 512 + 4 * t[6:0];
  endfunction

  // watchdog against a hung handshake
  initial
  begin
    repeat (95000) @(posedge clk);
    fail_count++;
    conclude();
  end

  // main sequence
  initial
  begin
    logic [31:0] q;
    logic [7:0] r;
    logic [7:0] t;
    logic [7:0] cv;
    logic [1:0] en;
    logic [1:0] fl;
    logic p;
    logic o;
    int c;
    int e;
    logic [7:0] trimTab [3] = '{8'h7F, 8'hC0, 8'h80};
    void'($urandom(59594));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    lacc(1'b0, ADDR_CONTROL, 8'h00, r);
    check("ctl reset", r, CONTROL_RESET);
    lacc(1'b0, ADDR_TRIM, 8'h00, r);
    check("trim reset", r, TRIM_RESET);
    lacc(1'b0, 5'h1F, 8'h00, r);
    check("unmapped dev", r, 8'h00);
    wb(1'b0, 8'h1C, 32'h0, q);
    check("unmapped host", q, 32'h0);
    check("pin reset", lnk.mfpLevel, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      o = k < 2 ? k[0] : 1'($urandom);
      lacc(1'b1, ADDR_CONTROL, {o, 7'h00}, r);
      check("gp level", lnk.mfpLevel, o);
    end
    for (int i = 0; i < 24; i++)
    begin
      p = i[0];
      en = 2'((i / 2) % 3 + 1);
      fl = 2'(i / 6);
      cv = {1'($urandom), 1'b0, en, 4'h0};
      lacc(1'b1, ADDR_WKDAY0, {~p, 7'h01}, r);
      lacc(1'b1, ADDR_WKDAY1, {p, 7'h02}, r);
      lacc(1'b1, ADDR_CONTROL, cv, r);
      @(posedge clk);
      m0 <= fl[0];
      m1 <= fl[1];
      @(posedge clk);
      m0 <= 1'b0;
      m1 <= 1'b0;
      repeat (3) @(posedge clk);
      check("alarm pin", lnk.mfpLevel, pinExp(cv, p, fl[0], fl[1]));
      lacc(1'b0, ADDR_WKDAY0, 8'h00, r);
      check("wkday0", r, {p, 3'h0, fl[0], 3'h1});
    end
    lacc(1'b1, ADDR_CONTROL, 8'h73, r);
    c = pinCount;
    repeat (400) @(posedge clk);
    check("sqw edges", (pinCount - c) inside {[99:101]}, 1'b1);
    lacc(1'b1, ADDR_CONTROL, 8'h44, r);
    for (int k = 0; k < 4; k++)
    begin
      t = k < 3 ? trimTab[k] : {1'($urandom), 7'($urandom_range(64, 1))};
      lacc(1'b1, ADDR_TRIM, t, r);
      repeat (3) @(posedge lnk.mfpLevel);
      @(negedge clk);
      c = oscCount;
      e = evCount;
      @(posedge lnk.mfpLevel);
      @(negedge clk);
      check("trim period", oscCount - c, trimPeriod(t));
      check("trim events", evCount - e, t[6:0] != 7'h00 ? 2 : 0);
    end
    wb(1'b1, HOST_IRQ_STAT, 32'h7, q);
    wb(1'b1, HOST_IRQ_MASK, 32'h2, q);
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, HOST_IDEAL, k ? 32'hFA : 32'h3E8, q);
      wb(1'b1, HOST_CAL, 32'hB, q);
      do wb(1'b0, HOST_IRQ_STAT, 32'h0, q); while (q[IRQ_CAL] !== 1'b1);
      @(posedge clk);
      check("cal irq", irq, 1'b1);
      wb(1'b0, HOST_RESULT, 32'h0, q);
      check("cal trim", q[7:0], k ? 8'h7F : 8'hFF);
      lacc(1'b0, ADDR_CONTROL, 8'h00, r);
      check("cal ctl", r, 8'hC3);
      wb(1'b1, HOST_IRQ_STAT, 32'h7, q);
      @(posedge clk);
      check("irq clear", irq, 1'b0);
    end
    lacc(1'b0, ADDR_TRIM, 8'h00, r);
    @(posedge clk);
    check("masked irq", irq, 1'b0);
    wb(1'b0, HOST_IRQ_STAT, 32'h0, q);
    check("access stat", q[IRQ_ACC], 1'b1);
    conclude();
  end
endmodule
